// ---- pix_blitter.sv ----
// Area fill and pixel block move engine with APB registers
//
// The register addresses and register access over APB were chosen for this implementation.
`include "blit_cfg.svh"
module pix_blitter (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Pixel memory read port
  output logic                       rd_valid,
  input  wire logic                  rd_ready,
  output logic [31:0]                rd_addr,
  input  wire logic [31:0]           rd_data,
  // Pixel memory write port
  output logic                       wr_valid,
  input  wire logic                  wr_ready,
  output blit_pkg::wr_beat_s         wr_beat,
  // Status
  output logic                       busy
);
  import blit_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {st_idle, st_src, st_dst, st_put} eng_state_e;

  logic [31:0] ctrl;
  logic [31:0] foreground_colour;
  logic [31:0] background_colour;
  logic [31:0] src_addr;
  logic [31:0] dst_addr;
  logic [31:0] src_pitch;
  logic [31:0] dst_pitch;
  logic [31:0] origin_offset;
  logic [4:0]  destination_pitch_conversion;
  logic [4:0]  src_conv;
  logic [31:0] extent;
  eng_state_e  state;
  logic        is_fill;
  logic        dst_xy;
  src_mode_e   smode;
  logic        transp;
  logic [4:0]  op;
  logic [15:0] width;
  logic [15:0] height;
  logic [15:0] x;
  logic [15:0] y;
  logic [31:0] s_row;
  logic [31:0] d_row;
  logic [31:0] src_pix;
  logic [31:0] dst_pix;
  logic [31:0] result;
  logic [31:0] src_word_addr;
  logic [31:0] src_xy_addr;
  logic [31:0] dst_lin;
  logic        wr_en;
  logic        rd_en;
  logic        start;
  logic        skip;
  logic        in_ready;
  logic        buf_empty;
  logic        last_x;
  logic        last_pix;
  logic        done;
  wr_beat_s    beat_in;

  // APB decode: zero wait states, every transfer answers in its access phase
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;
  assign start   = wr_en && (paddr == `OFS_CMD) && pwdata[`CMD_START] && (state == st_idle);
  assign busy    = (state != st_idle) || !buf_empty;

  // Unmapped or misaligned addresses answer with an error
  always_comb
  begin
    pslverr = 1'b0;
    if (psel && penable && ((paddr > `OFS_CMD) || (paddr[1:0] != 2'b00)))
      pslverr = 1'b1;
  end

  // Read mux; the command offset reads back engine status
  always_comb
  begin
    prdata = `RST_WORD;
    if (rd_en)
    begin
      case (paddr)
        `OFS_CTRL:      prdata = ctrl;
        `OFS_FG:        prdata = foreground_colour;
        `OFS_BG:        prdata = background_colour;
        `OFS_SRC_ADDR:  prdata = src_addr;
        `OFS_DST_ADDR:  prdata = dst_addr;
        `OFS_SRC_PITCH: prdata = src_pitch;
        `OFS_DST_PITCH: prdata = dst_pitch;
        `OFS_OFFSET:    prdata = origin_offset;
        `OFS_DST_CONV:  prdata = {27'h0, destination_pitch_conversion};
        `OFS_SRC_CONV:  prdata = {27'h0, src_conv};
        `OFS_EXTENT:    prdata = extent;
        `OFS_CMD:       prdata = {31'h0, busy};
        default:        prdata = `RST_WORD;
      endcase
    end
  end

  // Software-written setup registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl                         <= `RST_WORD;
      foreground_colour            <= `RST_WORD;
      background_colour            <= `RST_WORD;
      src_addr                     <= `RST_WORD;
      src_pitch                    <= `RST_WORD;
      dst_pitch                    <= `RST_WORD;
      origin_offset                <= `RST_WORD;
      destination_pitch_conversion <= `RST_CONV;
      src_conv                     <= `RST_CONV;
      extent                       <= `RST_WORD;
    end
    else if (wr_en)
    begin
      case (paddr)
        `OFS_CTRL:      ctrl <= pwdata;
        `OFS_FG:        foreground_colour <= pwdata;
        `OFS_BG:        background_colour <= pwdata;
        `OFS_SRC_ADDR:  src_addr <= pwdata;
        `OFS_SRC_PITCH: src_pitch <= pwdata;
        `OFS_DST_PITCH: dst_pitch <= pwdata;
        `OFS_OFFSET:    origin_offset <= pwdata;
        `OFS_DST_CONV:  destination_pitch_conversion <= pwdata[`CONV_HI:0];
        `OFS_SRC_CONV:  src_conv <= pwdata[`CONV_HI:0];
        `OFS_EXTENT:    extent <= pwdata;
        default:        ;
      endcase
    end
  end

  // Destination address: software loads it, the engine leaves it advanced
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dst_addr <= `RST_WORD;
    else if (done)
      dst_addr <= dst_xy ? {y + d_row[`HALF_HI:`HALF_MID_LO], d_row[`HALF_MID_HI:0]} : d_row + dst_pitch;
    else if (wr_en && (paddr == `OFS_DST_ADDR))
      dst_addr <= pwdata;
  end

  // ----------------------------------------------------------------
  // Operation setup latched at start
  // ----------------------------------------------------------------
  // Latching keeps a control or extent write during a run from bending the run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      is_fill <= 1'b0;
      dst_xy  <= 1'b0;
      smode   <= src_linear;
      transp  <= 1'b0;
      op      <= 5'h00;
      width   <= `RST_HALF;
      height  <= `RST_HALF;
    end
    else if (start)
    begin
      is_fill <= !pwdata[`CMD_KIND];
      dst_xy  <= ctrl[`CTRL_DST_XY];
      smode   <= src_mode_e'(ctrl[`CTRL_SRC_HI:`CTRL_SRC_LO]);
      transp  <= ctrl[`CTRL_TRANSP];
      op      <= ctrl[`CTRL_OP_HI:`CTRL_OP_LO];
      height  <= extent[`HALF_HI:`HALF_MID_LO];
      width   <= extent[`HALF_MID_HI:0];
    end
  end

  // ----------------------------------------------------------------
  // Address generation
  // ----------------------------------------------------------------
  // XY position goes through offset and shift; linear uses the row base only
  assign dst_lin = dst_xy
    ? origin_offset + ({16'h0, d_row[`HALF_HI:`HALF_MID_LO] + y} << destination_pitch_conversion)
      + {16'h0, d_row[`HALF_MID_HI:0] + x}
    : d_row + {16'h0, x};
  assign src_xy_addr = origin_offset
    + ({16'h0, s_row[`HALF_HI:`HALF_MID_LO] + y} << src_conv) + {16'h0, s_row[`HALF_MID_HI:0] + x};
  // Binary sources are bit addressed; the word holding the bit is fetched
  always_comb
  begin
    case (smode)
      src_xy:     src_word_addr = src_xy_addr;
      src_binary: src_word_addr = (s_row + {16'h0, x}) >> `WORD_SHIFT;
      default:    src_word_addr = s_row + {16'h0, x};
    endcase
  end

  assign rd_valid = (state == st_src) || (state == st_dst);
  assign rd_addr  = (state == st_src) ? src_word_addr : dst_lin;

  // ----------------------------------------------------------------
  // Engine
  // ----------------------------------------------------------------
  assign last_x   = (x == width - `ONE_HALF);
  assign last_pix = last_x && (y == height - `ONE_HALF);
  assign skip     = transp && (src_pix == `ZERO_PIX);
  assign done     = (state == st_put) && (skip || in_ready) && last_pix;

  // Sequencer: source read, destination read, then write back
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= st_idle;
    else
    begin
      case (state)
        st_idle:
          if (start)
            state <= (extent[`HALF_HI:`HALF_MID_LO] == `RST_HALF || extent[`HALF_MID_HI:0] == `RST_HALF)
              ? st_idle : (pwdata[`CMD_KIND] ? st_src : st_dst);
        st_src:
          if (rd_ready)
            state <= st_dst;
        st_dst:
          if (rd_ready)
            state <= st_put;
        st_put:
          if (skip || in_ready)
            state <= last_pix ? st_idle : (is_fill ? st_dst : st_src);
        default:
          state <= st_idle;
      endcase
    end
  end

  // Column and row counters; linear row bases stepped by the pitches, XY row bases held
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      x     <= `RST_HALF;
      y     <= `RST_HALF;
      s_row <= `RST_WORD;
      d_row <= `RST_WORD;
    end
    else if (start)
    begin
      x     <= `RST_HALF;
      y     <= `RST_HALF;
      s_row <= src_addr;
      d_row <= dst_addr;
    end
    else if ((state == st_put) && (skip || in_ready))
    begin
      if (last_x)
      begin
        x <= `RST_HALF;
        if (!last_pix)
        begin
          y     <= y + `ONE_HALF;
          s_row <= (smode == src_xy) ? s_row : s_row + src_pitch;
          d_row <= dst_xy ? d_row : d_row + dst_pitch;
        end
        else if (!dst_xy)
          d_row <= d_row + dst_pitch;
      end
      else
        x <= x + `ONE_HALF;
    end
  end

  // Source pixel capture: fill colour, expanded bit or fetched pixel
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      src_pix <= `ZERO_PIX;
    else if (start)
      src_pix <= foreground_colour;
    else if ((state == st_src) && rd_ready)
    begin
      if (smode == src_binary)
        src_pix <= rd_data[s_row[`BIT_IDX_HI:0] + x[`BIT_IDX_HI:0]]
          ? foreground_colour : background_colour;
      else
        src_pix <= rd_data;
    end
  end

  // Destination pixel capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dst_pix <= `ZERO_PIX;
    else if ((state == st_dst) && rd_ready)
      dst_pix <= rd_data;
  end

  // Combine; expanded pixels pass the same operation as any source
  pix_alu u_alu (
    .op     (op),
    .src    (src_pix),
    .dst    (dst_pix),
    .result (result)
  );

  assign beat_in.addr = dst_lin;
  assign beat_in.data = result;

  // Writes are posted; the buffer absorbs a memory stall of two beats
  pix_buffer #(
    .WIDTH (64),
    .DEPTH (2)
  ) u_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  ((state == st_put) && !skip),
    .in_ready  (in_ready),
    .in_data   (beat_in),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_beat),
    .empty     (buf_empty)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_fill_colour : assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_put) && is_fill |-> src_pix == foreground_colour)
    else $error("fill source is not the foreground colour");
  chk_extent_split : assert property (@(posedge pclk) disable iff (!presetn)
    start |=> (height == $past(extent[`HALF_HI:`HALF_MID_LO])) && (width == $past(extent[`HALF_MID_HI:0])))
    else $error("extent halves swapped");
  chk_op_field : assert property (@(posedge pclk) disable iff (!presetn)
    start |=> op == $past(ctrl[`CTRL_OP_HI:`CTRL_OP_LO]))
    else $error("operation not from control bits 14..10");
  chk_linear_start : assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_dst) && !dst_xy && (x == 16'h0000) && (y == 16'h0000) |-> rd_addr == d_row)
    else $error("linear fill does not start at destination address");
  chk_or_result : assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_put) && (op == 5'(op_or)) |-> result == (src_pix | dst_pix))
    else $error("OR result wrong");
  chk_expand_bit : assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_src) && rd_ready && (smode == src_binary) |=>
    (src_pix == foreground_colour) || (src_pix == background_colour))
    else $error("expanded pixel is neither colour");
  chk_transp_skip : assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_put) && transp && (src_pix == `ZERO_PIX) |=> $stable(buf_empty) || buf_empty)
    else $error("zero source pixel was written");
  chk_row_walk : assert property (@(posedge pclk) disable iff (!presetn)
    (state != st_idle) |-> (x < width) && (y < height))
    else $error("walk left the array");
  chk_daddr_moved : assert property (@(posedge pclk) disable iff (!presetn)
    done && !dst_xy |=> dst_addr == $past(d_row) + $past(dst_pitch))
    else $error("destination address not advanced");

  cov_fill : cover property (@(posedge pclk) disable iff (!presetn) done && is_fill);
  cov_expand : cover property (@(posedge pclk) disable iff (!presetn) done && (smode == src_binary));
  cov_stall : cover property (@(posedge pclk) disable iff (!presetn) (state == st_put) && !skip && !in_ready);
endmodule : pix_blitter

// ---- blit_cfg.svh ----
// Register map, field positions, reset values and rule summary of the blitter
// What this block does
// - An area fill takes the foreground colour as the source pixel for every destination pixel.
// - In XY mode the destination address holds the Y:X position of the upper-left pixel.
// - The extent register holds the height in its upper 16 bits and the width in its lower 16 bits.
// - The pixel operation field of the control register picks how source and destination combine.
// - After an operation the destination address register has moved and must be reloaded.
// - In linear mode the destination address is the linear address of the first pixel.
// - In linear mode the offset and pitch conversion registers have no effect.
// - The OR operation writes source OR old destination.
// - A block move reads from the source address and works on the array at the destination address.
// - Binary expand turns a 1 bit into the foreground colour and a 0 bit into the background colour.
// - The pixel operation is applied between expanded source pixels and destination pixels.
// - Six source/destination pairs exist: B-XY, B-L, L-L, XY-L, L-XY and XY-XY.
// - With transparency on, a zero source pixel leaves the destination untouched.
// - The pixel operation field sits in control bits 14 down to 10.
`ifndef BLIT_CFG_SVH
`define BLIT_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL      12'h000
`define OFS_FG        12'h004
`define OFS_BG        12'h008
`define OFS_SRC_ADDR  12'h00c
`define OFS_DST_ADDR  12'h010
`define OFS_SRC_PITCH 12'h014
`define OFS_DST_PITCH 12'h018
`define OFS_OFFSET    12'h01c
`define OFS_DST_CONV  12'h020
`define OFS_SRC_CONV  12'h024
`define OFS_EXTENT    12'h028
`define OFS_CMD       12'h02c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_DST_XY   0
`define CTRL_SRC_LO   1
`define CTRL_SRC_HI   2
`define CTRL_TRANSP   5
`define CTRL_OP_LO    10
`define CTRL_OP_HI    14
`define CMD_START     0
`define CMD_KIND      1
`define ST_BUSY       0
`define HALF_HI       31
`define HALF_MID_HI   15
`define HALF_MID_LO   16
`define CONV_HI       4
`define BIT_IDX_HI    4
`define WORD_SHIFT    5

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define RST_WORD      32'h0000_0000
`define RST_HALF      16'h0000
`define ONE_HALF      16'h0001
`define RST_CONV      5'h00
`define ZERO_PIX      32'h0000_0000
`define ALL_PIX       32'hffff_ffff

`endif

// ---- blit_pkg.sv ----
// Types shared by the blitter modules
package blit_pkg;
  typedef enum logic [1:0] {src_linear, src_xy, src_binary, src_spare} src_mode_e;
  typedef enum logic [4:0] {
    op_replace, op_and, op_andnot, op_zero, op_ornot, op_xnor, op_notdst, op_nor,
    op_or, op_keep, op_xor, op_srcandnot, op_ones, op_notsrcor, op_nand, op_notsrc,
    op_add, op_adds, op_sub, op_subs, op_max, op_min
  } pix_op_e;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } wr_beat_s;
endpackage : blit_pkg

// ---- pix_buffer.sv ----
// Two-entry buffer for write beats towards pixel memory
module pix_buffer #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Full stalls the engine, so a memory stall loses no beat
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign empty     = (count == '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = store[rd_ptr];

  // Storage entries
  always_ff @(posedge pclk)
  begin
    if (push)
      store[wr_ptr] <= in_data;
  end

  // Pointers and fill count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  chk_buf_hold : assert property (@(posedge pclk) disable iff (!presetn)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffer dropped a stalled beat");
endmodule : pix_buffer

// ---- pix_alu.sv ----
// Pixel operation between a source and a destination pixel
`include "blit_cfg.svh"
module pix_alu (
  // Operands
  input  wire logic [4:0]  op,
  input  wire logic [31:0] src,
  input  wire logic [31:0] dst,
  // Result
  output logic [31:0]      result
);
  import blit_pkg::*;
  logic [32:0] sum;
  logic [32:0] dif;

  // Saturating forms need the carry and borrow
  assign sum = {1'b0, dst} + {1'b0, src};
  assign dif = {1'b0, dst} - {1'b0, src};

  // Operation select; undefined codes fall back to replace
  always_comb
  begin
    case (pix_op_e'(op))
      op_replace:   result = src;
      op_and:       result = src & dst;
      op_andnot:    result = ~src & dst;
      op_zero:      result = `ZERO_PIX;
      op_ornot:     result = src | ~dst;
      op_xnor:      result = ~(src ^ dst);
      op_notdst:    result = ~dst;
      op_nor:       result = ~(src | dst);
      op_or:        result = src | dst;
      op_keep:      result = dst;
      op_xor:       result = src ^ dst;
      op_srcandnot: result = src & ~dst;
      op_ones:      result = `ALL_PIX;
      op_notsrcor:  result = ~src | dst;
      op_nand:      result = ~(src & dst);
      op_notsrc:    result = ~src;
      op_add:       result = sum[31:0];
      op_adds:      result = sum[32] ? `ALL_PIX : sum[31:0];
      op_sub:       result = dif[31:0];
      op_subs:      result = dif[32] ? `ZERO_PIX : dif[31:0];
      op_max:       result = (src > dst) ? src : dst;
      op_min:       result = (src < dst) ? src : dst;
      default:      result = src;
    endcase
  end
endmodule : pix_alu

// ---- pix_mem_model.sv ----
// Behavioural pixel memory on the far side of the blitter
module pix_mem_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Pace chosen by the bench
  input  wire logic        slow,
  // Read port
  input  wire logic        rd_valid,
  output logic             rd_ready,
  input  wire logic [31:0] rd_addr,
  output logic [31:0]      rd_data,
  // Write port
  input  wire logic        wr_valid,
  output logic             wr_ready,
  input  wire blit_pkg::wr_beat_s wr_beat
);
  timeunit 1ns;
  timeprecision 1ps;
  import blit_pkg::*;
  // ----------------------------------------
  // Storage and pacing
  // ----------------------------------------
  logic [31:0] mem [0:255];
  logic [1:0]  pace;
  logic [31:0] last = 32'h0;
  // Free-running pace so slow mode stalls reads while pace[0] is low and writes while pace[1] is low
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pace <= 2'h0;
    else
      pace <= pace + 2'h1;
  assign rd_ready = rd_valid && (!slow || pace[0]);
  assign wr_ready = !slow || pace[1];
  // Outside an answer the data lines show the inverse, never a stale word
  assign rd_data = rd_ready ? mem[rd_addr[7:0]] : ~last;
  // Plain always since the bench also preloads this array
  always @(posedge pclk)
  begin
    if (rd_ready)
      last <= mem[rd_addr[7:0]];
    if (wr_valid && wr_ready)
      mem[wr_beat.addr[7:0]] <= wr_beat.data;
  end
endmodule : pix_mem_model

// ---- testbench.sv ----
// Self-checking bench for the fill and block move engine
`include "blit_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import blit_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic        pclk = 1'b0, presetn = 1'b0, slow = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_addr, rd_data, r;
  logic        pready, pslverr, rd_valid, rd_ready, wr_valid, wr_ready, busy, e;
  wr_beat_s    wr_beat;
  int          num_errors = 0, checks = 0;
  always #12.5 pclk = ~pclk;
  pix_blitter dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rd_valid, .rd_ready, .rd_addr, .rd_data, .wr_valid, .wr_ready, .wr_beat, .busy);
  pix_mem_model mm (.pclk, .presetn, .slow, .rd_valid, .rd_ready, .rd_addr, .rd_data,
    .wr_valid, .wr_ready, .wr_beat);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 100);
    if (n >= 100)
      num_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task run(input logic [31:0] ctl, fg, bg, sa, sp, da, dp, ext, cmd);
    int n;
    n = 0;
    apb(1'b1, `OFS_CTRL, ctl);
    apb(1'b1, `OFS_FG, fg);
    apb(1'b1, `OFS_BG, bg);
    apb(1'b1, `OFS_SRC_ADDR, sa);
    apb(1'b1, `OFS_SRC_PITCH, sp);
    apb(1'b1, `OFS_DST_ADDR, da);
    apb(1'b1, `OFS_DST_PITCH, dp);
    apb(1'b1, `OFS_EXTENT, ext);
    apb(1'b1, `OFS_CMD, cmd);
    do @(posedge pclk); while (busy !== 1'b0 && ++n < 2000);
    chk("busy", {31'h0, busy}, 32'h0);
  endtask : run
  task preload;
    for (int i = 0; i < 256; i++)
      mm.mem[i] = 32'(i);
  endtask : preload
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    for (int a = 0; a <= 'h28; a += 4)
    begin
      apb(1'b0, a[11:0], 32'h0);
      chk("reset value", r, 32'h0);
    end
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped", {31'h0, e}, 32'h1);
  endtask : t_regs
  // Linear OR fill; junk in offset and conversion must not matter
  task t_fill_or;
    preload();
    apb(1'b1, `OFS_OFFSET, 32'h7);
    apb(1'b1, `OFS_DST_CONV, 32'h5);
    run(32'h2000, 32'h100, 32'h0, 32'h0, 32'h0, 32'h10, 32'h8, 32'h0002_0003, 32'h1);
    for (int y = 0; y < 3; y++)
      for (int x = 0; x < 4; x++)
        chk("or fill", mm.mem[16+y*8+x], 32'((y < 2 && x < 3) ? (16+y*8+x) | 'h100 : 16+y*8+x));
    apb(1'b0, `OFS_DST_ADDR, 32'h0);
    chk("dst moved", r, 32'h20);
  endtask : t_fill_or
  // XY replace fill with a stalling memory
  task t_area_paint_xy;
    preload();
    slow <= 1'b1;
    apb(1'b1, `OFS_OFFSET, 32'h4);
    apb(1'b1, `OFS_DST_CONV, 32'h3);
    run(32'h1, 32'hab, 32'h0, 32'h0, 32'h0, 32'h0001_0002, 32'h8, 32'h0002_0002, 32'h1);
    for (int y = 0; y < 2; y++)
      for (int x = 0; x < 3; x++)
        chk("xy fill", mm.mem[4+((1+y)<<3)+2+x], 32'(x < 2 ? 'hab : 4+((1+y)<<3)+2+x));
    slow <= 1'b0;
  endtask : t_area_paint_xy
  // Binary expand, transparent then OR with background, linear XOR copy, then XY to linear copy
  task t_expand;
    preload();
    mm.mem[64] = 32'h5;
    run(32'h24, 32'h77, 32'h0, 32'h800, 32'd32, 32'h50, 32'h8, 32'h0001_0004, 32'h3);
    for (int x = 0; x < 4; x++)
      chk("transparent", mm.mem[80+x], 32'(x % 2 ? 80+x : 'h77));
    run(32'h2004, 32'h100, 32'h9, 32'h800, 32'd32, 32'h58, 32'h8, 32'h0001_0004, 32'h3);
    for (int x = 0; x < 4; x++)
      chk("expand or", mm.mem[88+x], 32'((88+x) | (x % 2 ? 9 : 'h100)));
    run(32'h2800, 32'h0, 32'h0, 32'h60, 32'h8, 32'h70, 32'h8, 32'h0001_0002, 32'h3);
    for (int x = 0; x < 2; x++)
      chk("copy xor", mm.mem[112+x], 32'h10);
    // XY source through offset and source shift into a linear row
    apb(1'b1, `OFS_SRC_CONV, 32'h3);
    run(32'h2, 32'h0, 32'h0, 32'h0002_0001, 32'h0, 32'h78, 32'h8, 32'h0001_0002, 32'h3);
    for (int x = 0; x < 2; x++)
      chk("xy copy", mm.mem[120+x], 32'(21+x));
  endtask : t_expand
  // ----------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------
  task close_out;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_fill_or();
    t_area_paint_xy();
    t_expand();
    close_out();
  end
  // Whole run needs well under a few thousand cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    close_out();
  end
endmodule : testbench
